// *** rtl/tcc_defines.svh ***
/*
  shared constants of the measurement cycle and timeout block:
  register byte addresses, field positions, codes and times.
  assumes it is included by bare name from the top module and the bench.
*/
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// register byte addresses on the axi4-lite port
`define TCC_ADDR_CFG 8'h00
`define TCC_ADDR_CMD 8'h04
`define TCC_ADDR_STS 8'h08
`define TCC_ADDR_MASK 8'h0C
`define TCC_ADDR_RES_UP 8'h10
`define TCC_ADDR_RES_DN 8'h14
`define TCC_ADDR_STATE 8'h18

// status and mask bit positions
`define TCC_STS_TMO 0
`define TCC_STS_DONE 1
// command bit that launches a differential run
`define TCC_CMD_DIFF 0
// state register bit showing the fast oscillator enable
`define TCC_STATE_OSC 4

// reset values
`define TCC_CFG_RST 7'h00
`define TCC_MASK_RST 2'h0

// axi responses
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2

// repeat interval codes and slow clock counts
`define TCC_REP_KEEP_MAX 3'h5
`define TCC_REP_C0 10'h000
`define TCC_REP_C1 10'h004
`define TCC_REP_C2 10'h008
`define TCC_REP_C3 10'h010
`define TCC_REP_C4 10'h018
`define TCC_REP_C5 10'h020
`define TCC_REP_C6 10'h222
`define TCC_REP_C7 10'h28F
`define TCC_SLOW_SAT 10'h3FF

// timeout: smallest selectable time, largest code that doubles
`define TCC_TMO_BASE_US 128
`define TCC_TMO_CODE_MAX 3'h4
`define TCC_CLK_NS 100

// value read from a result register whose data are invalid
`define TCC_RES_INVALID 16'hFFFF

`endif

// *** rtl/tcc_pkg.sv ***
/*
  types of the measurement cycle and timeout block.
  assumes tcc_defines.svh is on the include path.
*/
package tcc_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    TCC_IDLE = 3'b000,
    TCC_UP = 3'b001,
    TCC_WAIT = 3'b010,
    TCC_DN = 3'b011
  } tcc_state_t;

  // configuration word, bits 6:0
  typedef struct packed {
    logic [2:0] rep;   // measure_repeat_interval
    logic rsvd;        // reserved, reads zero
    logic [2:0] tmo;   // hit_wait_limit_select
  } tcc_cfg_t;

  // one conversion result
  typedef struct packed {
    logic valid;
    logic [15:0] val;
  } tcc_res_t;
endpackage : tcc_pkg

// *** rtl/tcc_sync.sv ***
/*
  two flip-flop synchroniser for a vector of asynchronous pins.
  assumes the pins are levels that stay at least two clocks.
*/
module tcc_sync #(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_r; // first stage, read only by second stage

  // two stage capture
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '0;
      pin_sync <= '0;
    end else begin
      meta_r <= pin_in;
      pin_sync <= meta_r;
    end
  end
endmodule : tcc_sync

// *** rtl/tcc_top.sv ***
/*
  differential time-of-flight sequencer with repeat interval and
  hit timeout, axi4-lite register slave and level interrupt.
  assumes a 10 mhz mclk, a 32.768 khz slow clock and a stop hit pin,
  both asynchronous, and an axi4-lite master that holds its payload.
*/
// Notes on behaviour
// - codes 2-5 wait 8-32 ticks, oscillator on
// - codes 6,7 wait 546/655 ticks, oscillator off
// - timeout select doubles from 128 us up to code 4
// - timeout aborts run, sets timeout flag
// - timeout drives interrupt only when enabled
// - invalid result reads all ones after timeout
// - interval only for differential; overrun acts zero
// - interval counted in slow clock ticks
`include "tcc_defines.svh"
module tcc_top
  import tcc_pkg::*;
#(
  parameter int unsigned TMO_BASE_CYC =
    (`TCC_TMO_BASE_US * 1000 + `TCC_CLK_NS - 1) / `TCC_CLK_NS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic slow_clk_pin,
  input wire logic stop_hit_pin,
  output logic fast_osc_en_r,
  output logic irq_r,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // slow clock cycles for a repeat interval code
  function automatic logic [9:0] rep_slow(input logic [2:0] c);
    case (c)
      3'h0: rep_slow = `TCC_REP_C0;
      3'h1: rep_slow = `TCC_REP_C1;
      3'h2: rep_slow = `TCC_REP_C2;
      3'h3: rep_slow = `TCC_REP_C3;
      3'h4: rep_slow = `TCC_REP_C4;
      3'h5: rep_slow = `TCC_REP_C5;
      3'h6: rep_slow = `TCC_REP_C6;
      default: rep_slow = `TCC_REP_C7;
    endcase
  endfunction : rep_slow

  // mclk cycles for a timeout code; codes above the top saturate
  function automatic logic [15:0] tmo_lim(input logic [2:0] c);
    logic [2:0] s;
    s = (c > `TCC_TMO_CODE_MAX) ? `TCC_TMO_CODE_MAX : c;
    tmo_lim = 16'(TMO_BASE_CYC) << s;
  endfunction : tmo_lim

  // oscillator stays on in the gap for short intervals
  function automatic logic keep_osc(input logic [2:0] c);
    keep_osc = (c <= `TCC_REP_KEEP_MAX);
  endfunction : keep_osc

  logic [1:0] pin_sync;     // synchronised slow clock and stop hit
  logic tick_d_r;           // last slow clock level
  logic hit_d_r;            // last stop hit level
  logic tick;               // slow clock rising edge
  logic hit;                // stop hit rising edge

  // bus state
  logic bvalid_nxt, awready_nxt, rvalid_nxt, arready_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  tcc_cfg_t cfg_r, cfg_nxt;       // software configuration
  logic [1:0] mask_r, mask_nxt;   // interrupt mask
  logic start_cmd;                // differential_measure_cmd write
  logic [1:0] sts_clr;            // write-one-to-clear bits

  // measurement state
  tcc_state_t state_r, state_nxt;
  tcc_cfg_t run_r, run_nxt;       // configuration latched at start
  logic [9:0] slow_cnt_r, slow_cnt_nxt;   // ticks since upstream start
  logic [15:0] meas_cnt_r, meas_cnt_nxt;  // cycles in current leg
  tcc_res_t up_r, up_nxt, dn_r, dn_nxt;   // results
  logic [1:0] sts_r, sts_nxt;             // sticky events
  logic osc_nxt, irq_nxt;

  assign tick = pin_sync[0] & ~tick_d_r;
  assign hit = pin_sync[1] & ~hit_d_r;

  tcc_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in({stop_hit_pin, slow_clk_pin}),
    .pin_sync(pin_sync)
  );

  // bus next values: writes and reads, one of each at a time
  always_comb begin
    awready_nxt = 1'b0;
    bvalid_nxt = s_axi_bvalid & ~s_axi_bready;
    bresp_nxt = s_axi_bresp;
    arready_nxt = 1'b0;
    rvalid_nxt = s_axi_rvalid & ~s_axi_rready;
    rresp_nxt = s_axi_rresp;
    rdata_nxt = s_axi_rdata;
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    start_cmd = 1'b0;
    sts_clr = 2'h0;
    // write accepted with address and data together
    if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
      awready_nxt = 1'b1;
      bvalid_nxt = 1'b1;
      bresp_nxt = `TCC_RESP_OKAY;
      if (s_axi_awaddr == `TCC_ADDR_CFG) begin
        if (s_axi_wstrb[0]) begin
          cfg_nxt = tcc_cfg_t'(s_axi_wdata[6:0]);
          cfg_nxt.rsvd = 1'b0;
        end
      end else if (s_axi_awaddr == `TCC_ADDR_CMD) begin
        start_cmd = s_axi_wstrb[0] & s_axi_wdata[`TCC_CMD_DIFF];
      end else if (s_axi_awaddr == `TCC_ADDR_STS) begin
        if (s_axi_wstrb[0]) sts_clr = s_axi_wdata[1:0];
      end else if (s_axi_awaddr == `TCC_ADDR_MASK) begin
        if (s_axi_wstrb[0]) mask_nxt = s_axi_wdata[1:0];
      end else if (s_axi_awaddr == `TCC_ADDR_RES_UP ||
                   s_axi_awaddr == `TCC_ADDR_RES_DN ||
                   s_axi_awaddr == `TCC_ADDR_STATE) begin
        bresp_nxt = `TCC_RESP_OKAY; // read-only, write ignored
      end else begin
        bresp_nxt = `TCC_RESP_SLVERR;
      end
    end
    // read accepted, data captured at the handshake
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
      arready_nxt = 1'b1;
      rvalid_nxt = 1'b1;
      rresp_nxt = `TCC_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (s_axi_araddr == `TCC_ADDR_CFG) begin
        rdata_nxt[6:0] = cfg_r;
      end else if (s_axi_araddr == `TCC_ADDR_STS) begin
        rdata_nxt[1:0] = sts_r;
      end else if (s_axi_araddr == `TCC_ADDR_MASK) begin
        rdata_nxt[1:0] = mask_r;
      end else if (s_axi_araddr == `TCC_ADDR_RES_UP) begin
        rdata_nxt[15:0] = up_r.valid ? up_r.val : `TCC_RES_INVALID;
      end else if (s_axi_araddr == `TCC_ADDR_RES_DN) begin
        rdata_nxt[15:0] = dn_r.valid ? dn_r.val : `TCC_RES_INVALID;
      end else if (s_axi_araddr == `TCC_ADDR_STATE) begin
        rdata_nxt[2:0] = state_r;
        rdata_nxt[`TCC_STATE_OSC] = fast_osc_en_r;
      end else if (s_axi_araddr != `TCC_ADDR_CMD) begin
        rresp_nxt = `TCC_RESP_SLVERR;
      end
    end
  end

  // bus registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `TCC_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      cfg_r <= `TCC_CFG_RST;
      mask_r <= `TCC_MASK_RST;
    end else begin
      s_axi_awready <= awready_nxt;
      s_axi_wready <= awready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp <= rresp_nxt;
      s_axi_rdata <= rdata_nxt;
      cfg_r <= cfg_nxt;
      mask_r <= mask_nxt;
    end
  end

  // sequencer next values
  always_comb begin
    state_nxt = state_r;
    run_nxt = run_r;
    up_nxt = up_r;
    dn_nxt = dn_r;
    sts_nxt = sts_r & ~sts_clr; // a same-cycle set below wins
    meas_cnt_nxt = meas_cnt_r + 16'h0001;
    // interval measured in slow ticks from upstream start
    slow_cnt_nxt = slow_cnt_r;
    if (tick && slow_cnt_r != `TCC_SLOW_SAT)
      slow_cnt_nxt = slow_cnt_r + 10'h001;
    case (state_r)
      TCC_IDLE: begin
        meas_cnt_nxt = 16'h0000;
        if (start_cmd) begin
          state_nxt = TCC_UP;
          run_nxt = cfg_r;
          slow_cnt_nxt = 10'h000;
          up_nxt.valid = 1'b0;
          dn_nxt.valid = 1'b0;
        end
      end
      TCC_UP, TCC_DN: begin
        if (hit) begin
          if (state_r == TCC_UP) begin
            up_nxt = '{valid: 1'b1, val: meas_cnt_r};
            state_nxt = TCC_WAIT;
          end else begin
            dn_nxt = '{valid: 1'b1, val: meas_cnt_r};
            state_nxt = TCC_IDLE;
            sts_nxt[`TCC_STS_DONE] = 1'b1;
          end
        end else if (meas_cnt_r >= tmo_lim(run_r.tmo)) begin
          state_nxt = TCC_IDLE;
          sts_nxt[`TCC_STS_TMO] = 1'b1;
        end
      end
      TCC_WAIT: begin
        meas_cnt_nxt = 16'h0000;
        // overrun already past the interval starts at once
        if (slow_cnt_r >= rep_slow(run_r.rep))
          state_nxt = TCC_DN;
      end
      default: state_nxt = TCC_IDLE;
    endcase
    osc_nxt = (state_nxt == TCC_UP) || (state_nxt == TCC_DN) ||
              (state_nxt == TCC_WAIT && keep_osc(run_nxt.rep));
    // new mask and new status together, so irq never lags a mask write
    irq_nxt = |(sts_nxt & mask_nxt);
  end

  // sequencer registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_d_r <= 1'b0;
      hit_d_r <= 1'b0;
      state_r <= TCC_IDLE;
      run_r <= `TCC_CFG_RST;
      slow_cnt_r <= 10'h000;
      meas_cnt_r <= 16'h0000;
      up_r <= '0;
      dn_r <= '0;
      sts_r <= 2'h0;
      fast_osc_en_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      tick_d_r <= pin_sync[0];
      hit_d_r <= pin_sync[1];
      state_r <= state_nxt;
      run_r <= run_nxt;
      slow_cnt_r <= slow_cnt_nxt;
      meas_cnt_r <= meas_cnt_nxt;
      up_r <= up_nxt;
      dn_r <= dn_nxt;
      sts_r <= sts_nxt;
      fast_osc_en_r <= osc_nxt;
      irq_r <= irq_nxt;
    end
  end

  // checks
  AST_OSC_KEEP: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == TCC_WAIT && run_r.rep <= `TCC_REP_KEEP_MAX |-> fast_osc_en_r)
    else $error("oscillator off in a short gap");
  AST_OSC_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == TCC_WAIT && run_r.rep > `TCC_REP_KEEP_MAX |-> !fast_osc_en_r)
    else $error("oscillator on in a long gap");
  AST_EARLY_DN: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == TCC_WAIT && slow_cnt_r < rep_slow(run_r.rep)
    |=> state_r != TCC_DN)
    else $error("downstream started before interval");
  AST_TMO_BOUND: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == TCC_UP || state_r == TCC_DN
    |-> meas_cnt_r <= tmo_lim(run_r.tmo))
    else $error("leg ran past its timeout");
  AST_TMO_ABORT: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == TCC_UP || state_r == TCC_DN) && !hit &&
    meas_cnt_r == tmo_lim(run_r.tmo)
    |=> state_r == TCC_IDLE && sts_r[`TCC_STS_TMO])
    else $error("timeout did not abort and flag");
  AST_TMO_IRQ: assert property (@(posedge mclk) disable iff (sys_rst)
    sts_r[`TCC_STS_TMO] && mask_r[`TCC_STS_TMO] |-> irq_r ##0
    (irq_r == |(sts_r & mask_r)))
    else $error("interrupt does not follow enabled status");
  AST_RES_ONES: assert property (@(posedge mclk) disable iff (sys_rst)
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid &&
    s_axi_araddr == `TCC_ADDR_RES_UP && !up_r.valid
    |=> s_axi_rvalid && s_axi_rdata[15:0] == `TCC_RES_INVALID)
    else $error("invalid result not read as all ones");
  AST_OVERRUN: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == TCC_WAIT && slow_cnt_r >= rep_slow(run_r.rep)
    |=> state_r == TCC_DN)
    else $error("overrun did not start downstream at once");
  AST_TICK_ONLY: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r != TCC_IDLE && slow_cnt_r != $past(slow_cnt_r) &&
    slow_cnt_r != 10'h000 |-> $past(tick))
    else $error("interval count moved without a slow tick");
endmodule : tcc_top

// *** tb/tcc_far_model.sv ***
/*
  far side model: the slow crystal clock and the stop hit pin.
  assumes the bench calls fire() once per leg, after that leg starts.
*/
module tcc_far_model #(
  parameter int SLOW_HALF_NS = 1020
) (
  input wire logic mclk,
  output logic slow_clk_pin,
  output logic stop_hit_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // crystal runs free; sped up so the longest interval fits the run;
  // the half period keeps its edges off the rising edges of mclk
  initial begin
    slow_clk_pin = 1'b0;
    forever #(SLOW_HALF_NS) slow_clk_pin = ~slow_clk_pin;
  end
  initial stop_hit_pin = 1'b0;
  // one echo d cycles from now, held long enough for the synchroniser
  task automatic fire(input int d);
    repeat (d) @(posedge mclk);
    stop_hit_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    stop_hit_pin <= 1'b0;
  endtask : fire
endmodule : tcc_far_model

// *** tb/test_tof_cycle_and_timeout_config.sv ***
/*
  self-checking bench: axi4-lite host, timeout per code, repeat
  interval per code. assumes tcc_top and tcc_far_model are compiled.
*/
`include "tcc_defines.svh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin \
  failures++; $display("wrong value %s expected %0h seen %0h", \
  nm, e, s); end end
module test_tof_cycle_and_timeout_config;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, sys_rst = 1'b1, slow_clk_pin, stop_hit_pin;
  logic fast_osc_en_r, irq_r;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  int failures = 0, comparisons = 0;
  // slow ticks per interval code
  int reps[8] = '{0, 4, 8, 16, 24, 32, 546, 655};
  tcc_top #(.TMO_BASE_CYC(8)) dut (.*);
  tcc_far_model far (.mclk(mclk), .slow_clk_pin(slow_clk_pin),
    .stop_hit_pin(stop_hit_pin));
  // 10 mhz system clock
  always #50 mclk = ~mclk;
  // expected timeout in mclk cycles for the shortened base
  function automatic int tmo_lim(input int c);
    return 8 << ((c > 4) ? 4 : c);
  endfunction : tmo_lim
  // one write; address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    // a write that never got its response counts as a mismatch
    if (s_axi_bvalid !== 1'b1) failures++;
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // one read; rready held until rvalid is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    // a read that never got its data counts as a mismatch
    if (s_axi_rvalid !== 1'b1) failures++;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // watchdog cuts a hang short
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    summarize();
  end
  // main sequence
  initial begin
    int lim, n, d, t;
    realtime t0;
    logic osc, seen;
    void'($urandom(73));
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset values, unmapped places
    rd(`TCC_ADDR_MASK, rv, rs);
    `CHK("mask reset", 32'h0, rv)
    rd(`TCC_ADDR_RES_UP, rv, rs);
    `CHK("result at reset", 16'hFFFF, rv[15:0])
    rd(8'h40, rv, rs);
    `CHK("unmapped read", `TCC_RESP_SLVERR, rs)
    wr(8'h44, $urandom, rs);
    `CHK("unmapped write", `TCC_RESP_SLVERR, rs)
    // random fields, reserved bit written zero
    d = $urandom & 32'h77;
    wr(`TCC_ADDR_CFG, 32'(d), rs);
    rd(`TCC_ADDR_CFG, rv, rs);
    `CHK("cfg readback", 7'(d), rv[6:0])
    // no echo: every timeout code, mask alternating
    for (int c = 0; c < 8; c++) begin
      wr(`TCC_ADDR_MASK, 32'(c & 1), rs);
      wr(`TCC_ADDR_CFG, 32'(c), rs);
      wr(`TCC_ADDR_CMD, 32'h1, rs);
      n = 0;
      while (fast_osc_en_r === 1'b1 && n < 5000) begin
        @(posedge mclk);
        n++;
      end
      lim = tmo_lim(c);
      `CHK("timeout span", 1'b1, n >= lim - 4 && n <= lim + 2)
      repeat (3) @(posedge mclk);
      `CHK("irq on timeout", 1'(c & 1), irq_r)
      rd(`TCC_ADDR_STS, rv, rs);
      `CHK("timeout flag", 1'b1, rv[`TCC_STS_TMO])
      rd(`TCC_ADDR_RES_UP, rv, rs);
      `CHK("aborted result", 16'hFFFF, rv[15:0])
      wr(`TCC_ADDR_STS, 32'h3, rs);
      @(posedge mclk);
      `CHK("irq cleared", 1'b0, irq_r)
    end
    // reset in mid-run: sequencer, oscillator and config back to rest
    wr(`TCC_ADDR_CFG, 32'h75, rs);
    wr(`TCC_ADDR_CMD, 32'h1, rs);
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    `CHK("osc after reset", 1'b0, fast_osc_en_r)
    `CHK("irq after reset", 1'b0, irq_r)
    rd(`TCC_ADDR_STATE, rv, rs);
    `CHK("state after reset", 32'h0, rv)
    rd(`TCC_ADDR_CFG, rv, rs);
    `CHK("cfg after reset", 32'h0, rv)
    rd(`TCC_ADDR_RES_UP, rv, rs);
    `CHK("result after reset", 16'hFFFF, rv[15:0])
    // full differential runs, every interval code
    wr(`TCC_ADDR_MASK, 32'h0, rs);
    for (int c = 0; c < 8; c++) begin
      wr(`TCC_ADDR_CFG, 32'((c << 4) | 4), rs);
      wr(`TCC_ADDR_CMD, 32'h1, rs);
      t0 = $realtime;
      d = 5 + $urandom % 16;
      fork
        far.fire(d);
      join_none
      n = 0;
      seen = 1'b0;
      osc = 1'b0;
      do begin
        rd(`TCC_ADDR_STATE, rv, rs);
        if (rv[2:0] === 3'h2) begin
          seen = 1'b1;
          osc = rv[`TCC_STATE_OSC];
        end
        n++;
      end while (rv[2:0] !== 3'h3 && n < 5000);
      t = int'(($realtime - t0) / 2040.0);
      `CHK("ticks", 1'b1, t >= reps[c] - 1 && t <= reps[c] + 2)
      if (c > 0) `CHK("wait seen", 1'b1, seen)
      if (seen) `CHK("osc in wait", c <= 5, osc)
      rd(`TCC_ADDR_RES_UP, rv, rs);
      `CHK("up leg", 1'b1, rv[15:0] >= d && rv[15:0] <= d + 8)
      d = 5 + $urandom % 16;
      far.fire(d);
      n = 0;
      do begin
        rd(`TCC_ADDR_STS, rv, rs);
        n++;
      end while (rv[`TCC_STS_DONE] !== 1'b1 && n < 100);
      `CHK("done flag", 1'b1, rv[`TCC_STS_DONE])
      rd(`TCC_ADDR_RES_DN, rv, rs);
      `CHK("down leg", 1'b1, rv[15:0] >= d && rv[15:0] <= d + 14)
      wr(`TCC_ADDR_STS, 32'h3, rs);
    end
    summarize();
  end
endmodule : test_tof_cycle_and_timeout_config
